//--- epv_device.sv
/*
 * Device end: EPROM program/verify logic with code array, key table,
 * lock bits and signature read-out, all held in flip-flops.
 * Assumes link pins are asynchronous and pass two flip-flops first;
 * table_fetch_ext_i comes from logic on ref_clk_i.
 */
`default_nettype none

module epv_device (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Link
  epv_if.device     link,
  // Core side
  input  wire logic ext_access_i,
  input  wire logic table_fetch_ext_i,
  output logic [2:0] lock_bits_o,
  output logic      table_fetch_allow_o,
  output logic      ext_exec_allow_o,
  output logic      verify_block_o,
  output logic      ext_access_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    epv_pkg::epv_pins_t   s1;
    epv_pkg::epv_pins_t   s2;
    logic                 ea1;
    logic                 ea2;
    logic                 ea_lat;
    logic [1:0]           ea_wait;
    logic                 lat_prev;
    logic [11:0]          cnt;
    logic [2:0]           pulses;
    epv_pkg::epv_mode_t   pmode;
    logic [255:0][7:0]    code;
    logic [63:0][7:0]     key;
    logic [2:0]           lock;
    logic [7:0]           p0;
    logic                 p0_oe;
    logic                 fetch_ok;
    logic                 exec_ok;
    logic                 vfy_blk;
    logic                 ea_out;
  } epv_dev_state_t;

  epv_dev_state_t q;
  epv_dev_state_t d;

  epv_pkg::epv_mode_t mode;
  logic               fall;
  logic               rise;
  logic               lock1;
  logic               lock12;
  logic               lock123;
  logic               in_code;
  logic [7:0]         code_byte;
  logic [7:0]         key_byte;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;

    // Two-stage synchronisers for pins and the access strap
    d.s1  = link.pins;
    d.s2  = q.s1;
    d.s1.data = link.port0;
    d.ea1 = ext_access_i;
    d.ea2 = q.ea1;

    mode    = epv_pkg::epv_decode(q.s2);
    fall    = q.lat_prev && !q.s2.latch_pulse_pin;
    rise    = !q.lat_prev && q.s2.latch_pulse_pin;
    d.lat_prev = q.s2.latch_pulse_pin;

    // Protection levels, only the four nested states are honoured
    lock1   = q.lock[0];
    lock12  = q.lock[0] && q.lock[1];
    lock123 = &q.lock;

    in_code   = (q.s2.addr < 16'(epv_pkg::CODE_DEPTH));
    code_byte = q.code[q.s2.addr[7:0]];
    key_byte  = q.key[q.s2.addr[5:0]];

    // Edge-to-edge cycle count on the synced latch pin, runs on the
    // free-running oscillator the programmer keeps alive
    if (fall || rise) begin
      d.cnt = 12'h001;
    end else if (q.cnt != 12'hFFF) begin
      d.cnt = q.cnt + 12'h001;
    end

    // Pulse sequence belongs to one held program mode
    if (mode != q.pmode) begin
      d.pmode  = mode;
      d.pulses = 3'h0;
    end else if (!epv_pkg::epv_is_pgm(mode)) begin
      d.pulses = 3'h0;
    end else if (fall && q.cnt < epv_pkg::MIN_HIGH_CYC) begin
      d.pulses = 3'h0;
    end else if (rise) begin
      if (q.cnt < epv_pkg::MIN_LOW_CYC || q.cnt > epv_pkg::MAX_LOW_CYC) begin
        d.pulses = 3'h0;
      end else if (q.pulses + 3'h1 == epv_pkg::PULSES_PER_WR) begin
        d.pulses = 3'h0;
        case (mode)
          epv_pkg::EPV_PGM_CODE: begin
            if (q.lock == epv_pkg::LOCK_RST && in_code) begin
              d.code[q.s2.addr[7:0]] = q.s2.data;
            end
          end
          epv_pkg::EPV_PGM_KEY: begin
            if (q.lock == epv_pkg::LOCK_RST && q.s2.addr <= epv_pkg::KEY_LAST_ADDR) begin
              d.key[q.s2.addr[5:0]] = q.s2.data;
            end
          end
          epv_pkg::EPV_PGM_LOCK1: d.lock[0] = 1'b1;
          epv_pkg::EPV_PGM_LOCK2: d.lock[1] = 1'b1;
          epv_pkg::EPV_PGM_LOCK3: d.lock[2] = 1'b1;
          default: d.lock = q.lock;
        endcase
      end else begin
        d.pulses = q.pulses + 3'h1;
      end
    end

    // Port 0 read-out; the key only ever leaves mixed with code
    d.p0    = epv_pkg::BYTE_ERASED;
    d.p0_oe = 1'b0;
    case (mode)
      epv_pkg::EPV_VERIFY: begin
        if (!lock12) begin
          d.p0_oe = 1'b1;
          if (in_code) begin
            d.p0 = ~(code_byte ^ key_byte);
          end
        end
      end
      epv_pkg::EPV_SIGNATURE: begin
        d.p0_oe = 1'b1;
        if (q.s2.addr == epv_pkg::SIG_MFR_ADDR) begin
          d.p0 = epv_pkg::SIG_MFR_CODE;
        end else if (q.s2.addr == epv_pkg::SIG_PART_ADDR) begin
          d.p0 = epv_pkg::SIG_PART_CODE;
        end
      end
      default: d.p0_oe = 1'b0;
    endcase

    // Access strap caught once the synchroniser holds it, third edge after release
    if (q.ea_wait != 2'h3) begin
      d.ea_wait = q.ea_wait + 2'h1;
      d.ea_lat  = q.ea2;
    end

    // Core-side effects of the lock state
    d.fetch_ok = !(lock1 && table_fetch_ext_i);
    d.ea_out   = lock1 ? q.ea_lat : q.ea2;
    d.vfy_blk  = lock12;
    d.exec_ok  = !lock123;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q          <= '0;
      q.code     <= '1;
      q.key      <= '1;
      q.lock     <= epv_pkg::LOCK_RST;
      q.p0       <= epv_pkg::BYTE_ERASED;
      q.lat_prev <= 1'b1;
      q.s1.latch_pulse_pin <= 1'b1;
      q.s2.latch_pulse_pin <= 1'b1;
      q.cnt      <= 12'hFFF;
      q.fetch_ok <= 1'b1;
      q.exec_ok  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign link.p0_dev          = q.p0;
  assign link.p0_dev_oe       = q.p0_oe;
  assign lock_bits_o          = q.lock;
  assign table_fetch_allow_o  = q.fetch_ok;
  assign ext_exec_allow_o     = q.exec_ok;
  assign verify_block_o       = q.vfy_blk;
  assign ext_access_o         = q.ea_out;

endmodule : epv_device

`default_nettype wire

//--- epv_pkg.sv
/*
 * Shared constants, pin bundle, mode decode and timing for the
 * EPROM program/verify port: device end and programmer end.
 * Assumes one 20 MHz clock on both ends and a link joined by epv_if.
 */
// How it works
// - Programmer keeps the oscillator running throughout
// - Programmer drives address and data byte
// - Code programming levels with low pulses
// - Five low pulses write each location
// - Pulse low 100us +-10us, high 10us
// - Key table 0..1FH, select d low
// - Each lock bit has own select levels
// - Any lock bit blocks code, key writes
// - Verify drives addressed byte on port 0
// - Verify output is XNOR with key byte
// - Key table itself is never output
// - Signature bytes at 030H and 031H
// - Lock one: fetch block, access latched
// - Locks one and two disable verify
// - All three locks block external execution
// - Only four lock states are defined
// - Key table reads all ones initially
// - Reset pin high, strobe pin low always
`default_nettype none

package epv_pkg;

  // ----------------------------------------------------------------
  // Sizes and addresses
  // ----------------------------------------------------------------
  localparam int unsigned CODE_DEPTH    = 256;
  localparam int unsigned KEY_DEPTH     = 64;
  localparam logic [15:0] KEY_LAST_ADDR = 16'h001F;
  localparam logic [15:0] SIG_MFR_ADDR  = 16'h0030;
  localparam logic [15:0] SIG_PART_ADDR = 16'h0031;
  // Identity values are arbitrary
  localparam logic [7:0]  SIG_MFR_CODE  = 8'h5A;
  localparam logic [7:0]  SIG_PART_CODE = 8'hA7;
  localparam logic [7:0]  BYTE_ERASED   = 8'hFF;
  localparam logic [2:0]  LOCK_RST      = 3'h0;
  localparam logic [2:0]  PULSES_PER_WR = 3'h5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS        = 50;
  localparam int unsigned T_LOW_NS      = 100000;
  localparam int unsigned T_TOL_NS      = 10000;
  localparam int unsigned T_HIGH_NS     = 10000;
  localparam int unsigned T_GAP_NS      = 12000;
  localparam int unsigned T_SETTLE_NS   = 800;
  localparam logic [11:0] LOW_CYC       = 12'(T_LOW_NS / CLK_NS);
  localparam logic [11:0] MIN_LOW_CYC   = 12'((T_LOW_NS - T_TOL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] MAX_LOW_CYC   = 12'((T_LOW_NS + T_TOL_NS) / CLK_NS);
  localparam logic [11:0] MIN_HIGH_CYC  = 12'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] GAP_CYC       = 12'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] SETTLE_CYC    = 12'((T_SETTLE_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // Modes and pins
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EPV_NONE, EPV_SIGNATURE, EPV_VERIFY, EPV_PGM_CODE,
    EPV_PGM_KEY, EPV_PGM_LOCK1, EPV_PGM_LOCK2, EPV_PGM_LOCK3
  } epv_mode_t;

  // mode_sel is {a, b, c, d}
  typedef struct packed {
    logic        reset_pin;
    logic        program_store_strobe_pin;
    logic        latch_pulse_pin;
    logic        supply_vpp;
    logic        supply_high;
    logic [3:0]  mode_sel;
    logic [15:0] addr;
    logic [7:0]  data;
  } epv_pins_t;

  // Select levels a,b,c,d for each mode
  function automatic logic [3:0] epv_sel_of(input epv_mode_t m);
    case (m)
      EPV_PGM_CODE:  epv_sel_of = 4'hB;
      EPV_PGM_KEY:   epv_sel_of = 4'hA;
      EPV_PGM_LOCK1: epv_sel_of = 4'hF;
      EPV_PGM_LOCK2: epv_sel_of = 4'hC;
      EPV_PGM_LOCK3: epv_sel_of = 4'h5;
      EPV_VERIFY:    epv_sel_of = 4'h3;
      default:       epv_sel_of = 4'h0;
    endcase
  endfunction : epv_sel_of

  function automatic logic epv_is_pgm(input epv_mode_t m);
    epv_is_pgm = (m >= EPV_PGM_CODE);
  endfunction : epv_is_pgm

  // Mode recognised from the pin levels
  function automatic epv_mode_t epv_decode(input epv_pins_t p);
    epv_mode_t m;
    m = EPV_NONE;
    if (p.reset_pin && !p.program_store_strobe_pin) begin
      if (p.supply_vpp) begin
        for (int i = int'(EPV_PGM_CODE); i <= int'(EPV_PGM_LOCK3); i++) begin
          if (p.mode_sel == epv_sel_of(epv_mode_t'(i))) begin
            m = epv_mode_t'(i);
          end
        end
      end else if (p.supply_high && p.latch_pulse_pin) begin
        if (p.mode_sel == epv_sel_of(EPV_VERIFY)) begin
          m = EPV_VERIFY;
        end else if (p.mode_sel == epv_sel_of(EPV_SIGNATURE)) begin
          m = EPV_SIGNATURE;
        end
      end
    end
    return m;
  endfunction : epv_decode

endpackage : epv_pkg

`default_nettype wire

//--- epv_if.sv
/*
 * Pin-level link between the programmer end and the device end.
 * Assumes port 0 carries external pull-ups: undriven bits read high.
 */
`default_nettype none

interface epv_if;

  // ----------------------------------------------------------------
  // Programmer-driven pins
  // ----------------------------------------------------------------
  epv_pkg::epv_pins_t pins;
  logic               p0_prog_oe;

  // ----------------------------------------------------------------
  // Device-driven port 0
  // ----------------------------------------------------------------
  logic [7:0]         p0_dev;
  logic               p0_dev_oe;

  // Resolved port 0 level, pull-ups when nobody drives
  logic [7:0]         port0;
  assign port0 = p0_dev_oe  ? p0_dev :
                 p0_prog_oe ? pins.data : epv_pkg::BYTE_ERASED;

  modport device (
    input  pins,
    input  port0,
    output p0_dev,
    output p0_dev_oe
  );

  modport programmer (
    output pins,
    output p0_prog_oe,
    input  port0
  );

endinterface : epv_if

`default_nettype wire

//--- epv_programmer.sv
/*
 * Programmer end: turns one command into pin levels, five timed
 * latch pulses for program modes, or one port-0 sample for reads.
 * Assumes commands come from logic on ref_clk_i.
 */
`default_nettype none

module epv_programmer (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  // Link
  epv_if.programmer                link,
  // Command
  input  wire logic                cmd_valid_i,
  input  wire epv_pkg::epv_mode_t  cmd_op_i,
  input  wire logic [15:0]         cmd_addr_i,
  input  wire logic [7:0]          cmd_data_i,
  output logic                     cmd_ready_o,
  output logic                     done_o,
  output logic [7:0]               rdata_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_SETTLE
  } epv_prg_st_t;

  typedef struct packed {
    epv_prg_st_t         st;
    epv_pkg::epv_mode_t  op;
    logic [11:0]         cnt;
    logic [2:0]          pulses;
    epv_pkg::epv_pins_t  pins;
    logic                p0_oe;
    logic [7:0]          r1;
    logic [7:0]          r2;
    logic [7:0]          rdata;
    logic                done;
    logic                ready;
  } epv_prg_state_t;

  epv_prg_state_t q;
  epv_prg_state_t d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    d.r1   = link.port0;
    d.r2   = q.r1;
    if (q.cnt != 12'h000) begin
      d.cnt = q.cnt - 12'h001;
    end
    case (q.st)
      ST_IDLE: begin
        if (cmd_valid_i && cmd_op_i != epv_pkg::EPV_NONE) begin
          d.ready                          = 1'b0;
          d.op                             = cmd_op_i;
          d.pins.reset_pin                 = 1'b1;
          d.pins.program_store_strobe_pin  = 1'b0;
          d.pins.latch_pulse_pin           = 1'b1;
          d.pins.supply_vpp                = epv_pkg::epv_is_pgm(cmd_op_i);
          d.pins.supply_high               = 1'b1;
          d.pins.mode_sel                  = epv_pkg::epv_sel_of(cmd_op_i);
          d.pins.addr                      = cmd_addr_i;
          d.pins.data                      = cmd_data_i;
          d.p0_oe                          = 1'b0;
          d.pulses                         = 3'h0;
          d.cnt                            = epv_pkg::GAP_CYC;
          d.st                             = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Port 0 taken only once the device has let go of a verify drive
        if (q.cnt == epv_pkg::SETTLE_CYC) begin
          d.p0_oe = epv_pkg::epv_is_pgm(q.op);
        end
        if (q.cnt == 12'h000) begin
          if (epv_pkg::epv_is_pgm(q.op)) begin
            d.pins.latch_pulse_pin = 1'b0;
            d.cnt                  = epv_pkg::LOW_CYC;
            d.st                   = ST_LOW;
          end else begin
            d.cnt = epv_pkg::SETTLE_CYC;
            d.st  = ST_SETTLE;
          end
        end
      end
      ST_LOW: begin
        if (q.cnt == 12'h000) begin
          d.pins.latch_pulse_pin = 1'b1;
          d.pulses               = q.pulses + 3'h1;
          d.cnt                  = epv_pkg::GAP_CYC;
          d.st                   = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (q.cnt == 12'h000) begin
          if (q.pulses == epv_pkg::PULSES_PER_WR) begin
            d.pins.supply_vpp = 1'b0;
            d.p0_oe           = 1'b0;
            d.done            = 1'b1;
            d.ready           = 1'b1;
            d.st              = ST_IDLE;
          end else begin
            d.pins.latch_pulse_pin = 1'b0;
            d.cnt                  = epv_pkg::LOW_CYC;
            d.st                   = ST_LOW;
          end
        end
      end
      ST_SETTLE: begin
        if (q.cnt == 12'h000) begin
          d.rdata = q.r2;
          d.done  = 1'b1;
          d.ready = 1'b1;
          d.st    = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q                      <= '0;
      q.pins.reset_pin       <= 1'b1;
      q.pins.latch_pulse_pin <= 1'b1;
      q.pins.supply_high     <= 1'b1;
      q.ready                <= 1'b1;
      q.r1                   <= epv_pkg::BYTE_ERASED;
      q.r2                   <= epv_pkg::BYTE_ERASED;
    end else begin
      q <= d;
    end
  end

  assign link.pins       = q.pins;
  assign link.p0_prog_oe = q.p0_oe;
  assign cmd_ready_o     = q.ready;
  assign done_o          = q.done;
  assign rdata_o         = q.rdata;

endmodule : epv_programmer

`default_nettype wire

//--- epv_asserts.sv
/*
 * Link checker for the program/verify port: pulse shape, pulse count,
 * mode levels, port 0 ownership and signature read-out.
 * Assumes it is instantiated beside the epv_if that joins both ends.
 */
`default_nettype none

module epv_asserts (
  // Clock and reset
  input wire logic               ref_clk_i,
  input wire logic               rst_n_i,
  // Link signals
  input wire epv_pkg::epv_pins_t pins,
  input wire logic               p0_prog_oe,
  input wire logic [7:0]         p0_dev,
  input wire logic               p0_dev_oe,
  input wire logic [7:0]         port0
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [11:0] low_cnt_q;
  logic [11:0] high_cnt_q;
  logic [2:0]  pulse_cnt_q;
  logic        sig_lv;

  assign sig_lv = pins.reset_pin && !pins.program_store_strobe_pin && !pins.supply_vpp &&
                  pins.supply_high && pins.latch_pulse_pin && pins.mode_sel == 4'h0;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_q   <= 12'h000;
      high_cnt_q  <= 12'hFFF;
      pulse_cnt_q <= 3'h0;
    end else begin
      low_cnt_q  <= pins.latch_pulse_pin ? 12'h000 : low_cnt_q + 12'(low_cnt_q != 12'hFFF);
      high_cnt_q <= !pins.latch_pulse_pin ? 12'h000 : high_cnt_q + 12'(high_cnt_q != 12'hFFF);
      if ($fell(pins.supply_vpp) || ($past(pins.supply_vpp) && pins.supply_vpp && !$stable(pins.mode_sel))) begin
        pulse_cnt_q <= 3'h0;
      end else if ($fell(pins.latch_pulse_pin)) begin
        pulse_cnt_q <= pulse_cnt_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rst_strobe_a: assert property (pins.reset_pin && !pins.program_store_strobe_pin)
    else $error("reset or strobe pin left its program level");
  pulse_vpp_a: assert property (!pins.latch_pulse_pin |-> pins.supply_vpp)
    else $error("latch pulse without programming supply");
  pulse_sel_a: assert property (!pins.latch_pulse_pin |-> pins.mode_sel inside {4'hB, 4'hA, 4'hF, 4'hC, 4'h5})
    else $error("latch pulse under a non-program select level");
  pulse_width_a: assert property ($rose(pins.latch_pulse_pin) |->
      low_cnt_q inside {[epv_pkg::MIN_LOW_CYC:epv_pkg::MAX_LOW_CYC]})
    else $error("latch pulse low time out of range");
  pulse_gap_a: assert property ($fell(pins.latch_pulse_pin) |-> high_cnt_q >= epv_pkg::MIN_HIGH_CYC)
    else $error("latch pulse high gap too short");
  pulse_hold_a: assert property (!pins.latch_pulse_pin |->
      $stable({pins.mode_sel, pins.addr, pins.data, pins.supply_vpp}))
    else $error("levels moved during a latch pulse");
  pulse_count_a: assert property (($fell(pins.supply_vpp) ||
      ($past(pins.supply_vpp) && pins.supply_vpp && !$stable(pins.mode_sel))) |-> pulse_cnt_q == 3'h5)
    else $error("program step did not give five pulses");
  port_clash_a: assert property (!(p0_dev_oe && p0_prog_oe))
    else $error("both ends drive port 0");
  prog_quiet_a: assert property ($fell(pins.latch_pulse_pin) |-> !p0_dev_oe)
    else $error("device drives port 0 while programming");
  sig_mfr_a: assert property ((sig_lv && pins.addr == epv_pkg::SIG_MFR_ADDR)[*6] |->
      p0_dev_oe && p0_dev == epv_pkg::SIG_MFR_CODE && port0 == epv_pkg::SIG_MFR_CODE)
    else $error("maker signature byte wrong");
  sig_hidden_a: assert property ((sig_lv && $stable(pins.addr) && pins.addr[15:1] != 15'h0018)[*6] |->
      port0 == 8'hFF)
    else $error("signature read outside 030H and 031H not blank");

endmodule : epv_asserts

`default_nettype wire

//--- testbench.sv
/*
 * Self-checking bench: programmer end and device end joined by epv_if,
 * commands driven on the programmer, results checked against a model.
 * Assumes a 20 MHz clock and the command timing of the programmer end.
 */
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic               ref_clk_i         = 1'b0;
  logic               rst_n_i           = 1'b0;
  logic               ext_access_i      = 1'b0;
  logic               table_fetch_ext_i = 1'b0;
  logic               cmd_valid_i       = 1'b0;
  epv_pkg::epv_mode_t cmd_op_i          = epv_pkg::EPV_NONE;
  logic [15:0]        cmd_addr_i        = 16'h0000;
  logic [7:0]         cmd_data_i        = 8'h00;
  logic [2:0]         lock_bits_o;
  logic               table_fetch_allow_o;
  logic               ext_exec_allow_o;
  logic               verify_block_o;
  logic               ext_access_o;
  logic               cmd_ready_o;
  logic               done_o;
  logic [7:0]         rdata_o;
  logic [31:0]        rng_q             = 32'h2BC77E44;
  int                 fail_count        = 0;
  int                 checks_done       = 0;
  int                 code_m [256];
  int                 key_m [64];
  logic [2:0]         lock_m            = 3'h0;
  logic               strap;
  logic [15:0]        sig_a [3]         = '{16'h0030, 16'h0031, 16'h0005};
  logic [7:0]         sig_e [3]         = '{epv_pkg::SIG_MFR_CODE, epv_pkg::SIG_PART_CODE, 8'hFF};

  always #25 ref_clk_i = ~ref_clk_i;

  epv_if link_if ();

  epv_device epv_device_inst (
    .ref_clk_i           (ref_clk_i),
    .rst_n_i             (rst_n_i),
    .link                (link_if),
    .ext_access_i        (ext_access_i),
    .table_fetch_ext_i   (table_fetch_ext_i),
    .lock_bits_o         (lock_bits_o),
    .table_fetch_allow_o (table_fetch_allow_o),
    .ext_exec_allow_o    (ext_exec_allow_o),
    .verify_block_o      (verify_block_o),
    .ext_access_o        (ext_access_o)
  );

  epv_programmer epv_programmer_inst (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .link        (link_if),
    .cmd_valid_i (cmd_valid_i),
    .cmd_op_i    (cmd_op_i),
    .cmd_addr_i  (cmd_addr_i),
    .cmd_data_i  (cmd_data_i),
    .cmd_ready_o (cmd_ready_o),
    .done_o      (done_o),
    .rdata_o     (rdata_o)
  );

  epv_asserts epv_asserts_inst (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .pins       (link_if.pins),
    .p0_prog_oe (link_if.p0_prog_oe),
    .p0_dev     (link_if.p0_dev),
    .p0_dev_oe  (link_if.p0_dev_oe),
    .port0      (link_if.port0)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q;
  endfunction : rnd

  function automatic logic [7:0] vexp(input logic [15:0] a);
    if (a > 16'h00FF || (lock_m[0] && lock_m[1])) begin
      return 8'hFF;
    end
    return ~(8'(code_m[a[7:0]]) ^ 8'(key_m[a[5:0]]));
  endfunction : vexp

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // Entered just after an edge; returns just after the edge that shows done
  task automatic run_cmd(input epv_pkg::epv_mode_t op, input logic [15:0] a, input logic [7:0] d);
    int n;
    cmd_op_i    = op;
    cmd_addr_i  = a;
    cmd_data_i  = d;
    cmd_valid_i = 1'b1;
    @(posedge ref_clk_i);
    #2;
    cmd_valid_i = 1'b0;
    check(8'(cmd_ready_o), 8'h00);
    cmd_addr_i  = 16'(rnd());
    cmd_data_i  = 8'(rnd());
    n = 0;
    while (done_o !== 1'b1 && n < 13000) begin
      @(posedge ref_clk_i);
      #2;
      n++;
    end
    check({cmd_ready_o, 7'(n < 13000)}, 8'h81);
  endtask : run_cmd

  task automatic prog(input epv_pkg::epv_mode_t op, input logic [15:0] a, input logic [7:0] d);
    if (op == epv_pkg::EPV_PGM_CODE && lock_m == 3'h0) code_m[a[7:0]] = d;
    if (op == epv_pkg::EPV_PGM_KEY && lock_m == 3'h0 && a <= 16'h001F) key_m[a[5:0]] = d;
    if (op == epv_pkg::EPV_PGM_LOCK1) lock_m[0] = 1'b1;
    if (op == epv_pkg::EPV_PGM_LOCK2) lock_m[1] = 1'b1;
    if (op == epv_pkg::EPV_PGM_LOCK3) lock_m[2] = 1'b1;
    run_cmd(op, a, d);
    repeat (4) @(posedge ref_clk_i);
    #2;
    check(8'(lock_bits_o), 8'(lock_m));
  endtask : prog

  task automatic rd(input epv_pkg::epv_mode_t op, input logic [15:0] a, input logic [7:0] exp);
    run_cmd(op, a, 8'(rnd()));
    check(rdata_o, exp);
  endtask : rd

  // Core-side levels, compared after they have crossed the synchroniser
  task automatic flags();
    logic [31:0] r;
    r = rnd();
    table_fetch_ext_i = r[0];
    ext_access_i      = r[1];
    repeat (6) @(posedge ref_clk_i);
    #2;
    check({4'h0, ext_exec_allow_o, verify_block_o, table_fetch_allow_o, ext_access_o},
          {4'h0, lock_m != 3'h7, lock_m[0] && lock_m[1], !(lock_m[0] && table_fetch_ext_i),
           lock_m[0] ? strap : ext_access_i});
  endtask : flags

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] a;
    foreach (code_m[i]) code_m[i] = 255;
    foreach (key_m[i]) key_m[i] = 255;
    r = rnd();
    strap = r[0];
    ext_access_i = r[0];
    repeat (2) @(posedge ref_clk_i);
    #2;
    rst_n_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #2;
    flags();
    r = rnd();
    a = {8'h00, r[7:6], 1'b0, r[4:0]};
    rd(epv_pkg::EPV_VERIFY, a, 8'hFF);
    prog(epv_pkg::EPV_PGM_CODE, a, r[15:8]);
    rd(epv_pkg::EPV_VERIFY, a, vexp(a));
    for (int i = 0; i < 3; i++) rd(epv_pkg::EPV_SIGNATURE, sig_a[i], sig_e[i]);
    prog(epv_pkg::EPV_PGM_KEY, {11'h000, a[4:0]}, r[23:16]);
    rd(epv_pkg::EPV_VERIFY, a, vexp(a));
    rd(epv_pkg::EPV_VERIFY, 16'h0100, 8'hFF);
    prog(epv_pkg::EPV_PGM_LOCK1, a, r[15:8]);
    flags();
    prog(epv_pkg::EPV_PGM_CODE, a, ~r[15:8]);
    rd(epv_pkg::EPV_VERIFY, a, vexp(a));
    prog(epv_pkg::EPV_PGM_LOCK2, a, r[15:8]);
    flags();
    rd(epv_pkg::EPV_VERIFY, a, 8'hFF);
    prog(epv_pkg::EPV_PGM_LOCK3, a, r[15:8]);
    flags();
    summarize();
  end

  initial begin
    repeat (90000) @(posedge ref_clk_i);
    fail_count++;
    summarize();
  end

endmodule : testbench

`default_nettype wire
